// ### hdl/urxf_receiver.sv
// Receive half of an asynchronous serial port with a four-word FIFO.
// Assumes all inputs synchronous to core_clk_i; status/data read strobes
// are single-cycle pulses from the surrounding register logic.
//
// Function
// - Serial bits enter the shift register least significant bit first.
// - FIFO holds four words while a fifth assembles in the shift register.
// - Word length, parity, stop bits and baud settings shape each frame.
// - Setting receive enable takes the pin and starts start-bit hunting.
// - Data-available flag while FIFO holds data; buffered count readable.
// - With interrupts enabled, request when FIFO reaches trigger level.
// - Data-available clears only after status read then data read.
// - Break is a framing error, complete after data plus stop bit times.
// - Break loads zero word, sets framing, available and idle flags.
// - After break, wait for high line before hunting next start.
// - Idle falls at start detection, rises at frame end; a rejected glitch start keeps it low.
// - Overrun also requests an interrupt when interrupts enabled.
// - Overrun sets flag, keeps FIFO, shift register gets overwritten.
// - Overrun flag clears on status access followed by data read.
// - Line is oversampled to recover bits and detect noise.
// - Noisy word still stored; noise flag rises with data-available.
// - Noise flag clears on status read followed by data read.
// - Sixteen-times oversampling with three-sample majority per bit.
// - Framing error if any expected stop bit samples low.
// - Parity error on mismatch with even, odd, mark or space type.
module urxf_receiver (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic serial_in_pin_i,
  input wire logic rx_enable_i,
  input wire logic word_len_sel_i,
  input wire logic parity_enable_i,
  input wire logic [1:0] parity_type_sel_i,
  input wire logic stop_count_sel_i,
  input wire logic [7:0] baud_div_high_i,
  input wire logic [7:0] baud_div_low_i,
  input wire logic [2:0] baud_mode_sel_i,
  input wire logic rx_irq_enable_i,
  input wire logic [1:0] fifo_trig_sel_i,
  input wire logic status_rd_i,
  input wire logic data_rd_i,
  output logic rx_pin_owned_o,
  output logic [8:0] rx_data_fifo_reg_o,
  output logic [2:0] rx_count_reg_o,
  output logic rx_avail_flag_o,
  output logic rx_idle_flag_o,
  output logic overrun_flag_o,
  output logic noise_flag_o,
  output logic framing_flag_o,
  output logic parity_flag_o,
  output logic rx_irq_o
);

  // ----------------------------------------------------------------
  // Oversample tick generator
  // ----------------------------------------------------------------
  logic [urxf_pkg::PRESC_W-1:0] presc_q;
  logic [urxf_pkg::PRESC_W-1:0] presc_lim;
  logic tick;
  assign presc_lim = baud_mode_sel_i[urxf_pkg::BAUD_FAST_BIT] ?
                     {2'h0, baud_div_high_i, baud_div_low_i} :
                     {baud_div_high_i, baud_div_low_i, 2'h3};
  assign tick = (presc_q >= presc_lim);

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i || !rx_enable_i || tick) begin
      presc_q <= '0;
    end else begin
      presc_q <= presc_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Receive state machine
  // ----------------------------------------------------------------
  urxf_pkg::urxf_state_t state_q;
  logic [3:0] os_q;
  logic [2:0] smp_q;
  logic [3:0] bit_idx_q;
  logic [8:0] shift_q;
  logic frame_noise_q;
  logic frame_ferr_q;
  logic vote;
  logic vote_noisy;
  logic at_vote;
  logic [3:0] word_bits;
  logic frame_done;
  logic frame_ferr;
  logic par_bit;
  logic data_xor;
  logic par_err;
  logic [8:0] data_word;
  // Majority of three samples around mid-bit
  assign vote = (smp_q[0] & smp_q[1]) | (smp_q[1] & smp_q[2]) | (smp_q[0] & smp_q[2]);
  assign vote_noisy = (smp_q != 3'h0) && (smp_q != 3'h7);
  assign at_vote = tick && (os_q == urxf_pkg::OS_VOTE_PT);
  assign word_bits = word_len_sel_i ? urxf_pkg::WORD_BITS_LONG : urxf_pkg::WORD_BITS_SHORT;

  // Any low stop bit is a framing error
  assign frame_ferr = frame_ferr_q | !vote;
  assign frame_done = at_vote &&
                      ((state_q == urxf_pkg::URXF_STOP2) ||
                       ((state_q == urxf_pkg::URXF_STOP1) && !stop_count_sel_i));

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      smp_q <= 3'h7;
    end else if (tick) begin
      smp_q <= {smp_q[1:0], serial_in_pin_i};
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i || !rx_enable_i) begin
      // Dropping enable aborts the frame, the restart path after a stall
      state_q <= urxf_pkg::URXF_OFF;
      os_q <= 4'h0;
      bit_idx_q <= 4'h0;
    end else if (tick) begin
      os_q <= os_q + 1'b1;
      case (state_q)
        // Enable starts the hunt once line is high
        urxf_pkg::URXF_OFF: begin
          state_q <= urxf_pkg::URXF_WAIT_HIGH;
        end
        // Long low line is not a new start
        urxf_pkg::URXF_WAIT_HIGH: begin
          if (serial_in_pin_i) begin
            state_q <= urxf_pkg::URXF_HUNT;
          end
        end
        urxf_pkg::URXF_HUNT: begin
          os_q <= 4'h0;
          if (!serial_in_pin_i) begin
            state_q <= urxf_pkg::URXF_START;
            os_q <= 4'h1;
          end
        end
        urxf_pkg::URXF_START: begin
          // A start bit that votes high was a glitch
          if (at_vote && vote) begin
            state_q <= urxf_pkg::URXF_HUNT;
          end else if (os_q == urxf_pkg::OS_LAST) begin
            state_q <= urxf_pkg::URXF_DATA;
            bit_idx_q <= 4'h0;
          end
        end
        urxf_pkg::URXF_DATA: begin
          if (os_q == urxf_pkg::OS_LAST) begin
            bit_idx_q <= bit_idx_q + 1'b1;
            if (bit_idx_q == word_bits - 1'b1) begin
              state_q <= urxf_pkg::URXF_STOP1;
            end
          end
        end
        urxf_pkg::URXF_STOP1: begin
          if (at_vote) begin
            state_q <= stop_count_sel_i ? urxf_pkg::URXF_STOP2 : urxf_pkg::URXF_WAIT_HIGH;
            os_q <= stop_count_sel_i ? 4'ha : 4'h0;
          end
        end
        // Frame ends after set bit count, however long the break
        urxf_pkg::URXF_STOP2: begin
          if (at_vote) begin
            state_q <= urxf_pkg::URXF_WAIT_HIGH;
          end
        end
        default: begin
          state_q <= urxf_pkg::URXF_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    // New frame overwrites the unsaved word
    if (!nrst_i || (tick && state_q == urxf_pkg::URXF_START)) begin
      shift_q <= urxf_pkg::WORD_RST;
    end else if (at_vote && state_q == urxf_pkg::URXF_DATA) begin
      shift_q[bit_idx_q] <= vote;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i || (tick && state_q == urxf_pkg::URXF_HUNT)) begin
      frame_noise_q <= 1'b0;
      frame_ferr_q <= 1'b0;
    end else if (at_vote) begin
      frame_noise_q <= frame_noise_q | vote_noisy;
      if (state_q == urxf_pkg::URXF_STOP1) begin
        frame_ferr_q <= !vote;
      end
    end
  end

  // ----------------------------------------------------------------
  // Parity check; parity occupies the top position of the word
  // ----------------------------------------------------------------
  assign par_bit = shift_q[word_bits - 1'b1];
  assign data_word = parity_enable_i ?
                     (shift_q & ~(9'h001 << (word_bits - 1'b1))) : shift_q;
  assign data_xor = ^data_word;

  always_comb begin
    case (parity_type_sel_i)
      urxf_pkg::PAR_EVEN: par_err = data_xor ^ par_bit;
      urxf_pkg::PAR_ODD: par_err = !(data_xor ^ par_bit);
      urxf_pkg::PAR_MARK: par_err = !par_bit;
      urxf_pkg::PAR_SPACE: par_err = par_bit;
      default: par_err = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Receive FIFO
  // ----------------------------------------------------------------
  logic [8:0] fifo_mem [urxf_pkg::FIFO_DEPTH];
  logic [1:0] wr_ptr_q;
  logic [1:0] rd_ptr_q;
  logic [2:0] count_q;
  logic push;
  logic pop;
  logic overrun_ev;
  assign push = frame_done && (count_q != urxf_pkg::FIFO_FULL_CNT);
  assign overrun_ev = frame_done && (count_q == urxf_pkg::FIFO_FULL_CNT);
  assign pop = data_rd_i && (count_q != 3'h0);

  always_ff @(posedge core_clk_i) begin
    if (push) begin
      fifo_mem[wr_ptr_q] <= data_word;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      wr_ptr_q <= 2'h0;
      rd_ptr_q <= 2'h0;
      count_q <= 3'h0;
    end else begin
      wr_ptr_q <= wr_ptr_q + {1'b0, push};
      rd_ptr_q <= rd_ptr_q + {1'b0, pop};
      count_q <= count_q + {2'h0, push} - {2'h0, pop};
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      rx_data_fifo_reg_o <= urxf_pkg::WORD_RST;
    end else if (pop) begin
      rx_data_fifo_reg_o <= fifo_mem[rd_ptr_q];
    end
  end

  // ----------------------------------------------------------------
  // Status flags; a set in the clearing cycle wins
  // ----------------------------------------------------------------
  logic armed_q;
  logic clr_seq;
  logic avail_q;
  logic ovr_q;
  logic noise_q;
  logic ferr_q;
  logic perr_q;
  logic idle_q;
  // Status access arms the clear; the following data read fires it
  assign clr_seq = armed_q && data_rd_i;

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      armed_q <= 1'b0;
    end else if (status_rd_i) begin
      armed_q <= 1'b1;
    end else if (data_rd_i) begin
      armed_q <= 1'b0;
    end
  end

  // Cleared only by the read sequence emptying the FIFO
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      avail_q <= 1'b0;
    end else if (push) begin
      avail_q <= 1'b1;
    end else if (clr_seq && count_q == 3'h1) begin
      avail_q <= 1'b0;
    end
  end

  // Overrun set and cleared by read sequence
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      ovr_q <= 1'b0;
    end else if (overrun_ev) begin
      ovr_q <= 1'b1;
    end else if (clr_seq) begin
      ovr_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      noise_q <= 1'b0;
    end else if (push && frame_noise_q) begin
      noise_q <= 1'b1;
    end else if (clr_seq) begin
      noise_q <= 1'b0;
    end
  end

  // Break word lands with framing flag set
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      ferr_q <= 1'b0;
      perr_q <= 1'b0;
    end else if (push) begin
      ferr_q <= ferr_q | frame_ferr;
      perr_q <= perr_q | (parity_enable_i & par_err);
    end else if (clr_seq) begin
      ferr_q <= 1'b0;
      perr_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      idle_q <= 1'b1;
    end else if (tick && state_q == urxf_pkg::URXF_HUNT && !serial_in_pin_i) begin
      idle_q <= 1'b0;
    end else if (frame_done || !rx_enable_i) begin
      idle_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic [2:0] trig_lvl;
  assign trig_lvl = {1'b0, fifo_trig_sel_i} + 3'h1;
  assign rx_pin_owned_o = rx_enable_i;
  assign rx_count_reg_o = count_q;
  assign rx_avail_flag_o = avail_q;
  assign rx_idle_flag_o = idle_q;
  assign overrun_flag_o = ovr_q;
  assign noise_flag_o = noise_q;
  assign framing_flag_o = ferr_q;
  assign parity_flag_o = perr_q;
  assign rx_irq_o = rx_irq_enable_i & ((count_q >= trig_lvl) | ovr_q);

endmodule // urxf_receiver

// ### common/urxf_pkg.sv
// Constants and types shared by the receive path of the serial port.
// Assumes a single core clock domain; no bus, all controls are plain ports.
package urxf_pkg;

  // ----------------------------------------------------------------
  // Oversampling and framing
  // ----------------------------------------------------------------
  localparam int unsigned OS_RATE = 16;
  localparam logic [3:0] OS_LAST = 4'hf;
  localparam logic [3:0] OS_VOTE_PT = 4'h9;
  localparam logic [3:0] WORD_BITS_SHORT = 4'h8;
  localparam logic [3:0] WORD_BITS_LONG = 4'h9;
  localparam int unsigned WORD_W = 9;

  // ----------------------------------------------------------------
  // Receive FIFO
  // ----------------------------------------------------------------
  localparam int unsigned FIFO_DEPTH = 4;
  localparam logic [2:0] FIFO_FULL_CNT = 3'h4;
  localparam logic [8:0] WORD_RST = 9'h000;

  // ----------------------------------------------------------------
  // Baud prescale: slow mode stretches each oversample tick by four
  // ----------------------------------------------------------------
  localparam int unsigned PRESC_W = 18;
  localparam int unsigned BAUD_FAST_BIT = 0;

  // ----------------------------------------------------------------
  // Parity types
  // ----------------------------------------------------------------
  localparam logic [1:0] PAR_EVEN = 2'h0;
  localparam logic [1:0] PAR_ODD = 2'h1;
  localparam logic [1:0] PAR_MARK = 2'h2;
  localparam logic [1:0] PAR_SPACE = 2'h3;

  typedef enum logic [2:0] {
    URXF_OFF,
    URXF_WAIT_HIGH,
    URXF_HUNT,
    URXF_START,
    URXF_DATA,
    URXF_STOP1,
    URXF_STOP2
  } urxf_state_t;

endpackage

// ### verification/urxf_checker.sv
// Concurrent checks on the receiver's ports.
// Assumes one core clock and the synchronous active-low reset.
module urxf_checker (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic rx_enable_i,
  input wire logic rx_irq_enable_i,
  input wire logic [1:0] fifo_trig_sel_i,
  input wire logic data_rd_i,
  input wire logic rx_pin_owned_o,
  input wire logic [2:0] rx_count_reg_o,
  input wire logic rx_avail_flag_o,
  input wire logic rx_idle_flag_o,
  input wire logic overrun_flag_o,
  input wire logic noise_flag_o,
  input wire logic rx_irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  // -----------------------------------------------
  // Sequences
  // -----------------------------------------------
  // A read with no frame ending nearby, so no push can overlap it
  sequence s_quiet_read;
    data_rd_i && rx_count_reg_o != 3'h0 && rx_idle_flag_o && $past(rx_idle_flag_o);
  endsequence
  sequence s_stop_seen;
    rx_enable_i && $past(rx_enable_i) && $rose(rx_idle_flag_o);
  endsequence

  // -----------------------------------------------
  // Properties
  // -----------------------------------------------
  property p_irq;
    rx_irq_o == (rx_irq_enable_i && (rx_count_reg_o > {1'b0, fifo_trig_sel_i} || overrun_flag_o));
  endproperty
  property p_pin;
    rx_pin_owned_o == rx_enable_i;
  endproperty
  property p_depth;
    rx_count_reg_o <= 3'h4;
  endproperty
  property p_avail;
    rx_count_reg_o != 3'h0 |-> rx_avail_flag_o;
  endproperty
  property p_read;
    s_quiet_read |=> rx_count_reg_o == $past(rx_count_reg_o) - 3'h1;
  endproperty
  property p_push;
    s_stop_seen |-> ##[0:1] (rx_count_reg_o != 3'h0 || overrun_flag_o);
  endproperty
  property p_ovr_full;
    $rose(overrun_flag_o) |-> rx_count_reg_o == 3'h4;
  endproperty
  property p_ovr_hold;
    overrun_flag_o && !data_rd_i |=> overrun_flag_o;
  endproperty
  property p_noise;
    $rose(noise_flag_o) |-> rx_avail_flag_o;
  endproperty

  a_irq: assert property (p_irq) else $error("irq mismatch");
  a_pin: assert property (p_pin) else $error("pin owner mismatch");
  a_depth: assert property (p_depth) else $error("count above depth");
  a_avail: assert property (p_avail) else $error("avail low with data");
  a_read: assert property (p_read) else $error("count not decremented");
  a_push: assert property (p_push) else $error("no word after stop");
  a_ovr_full: assert property (p_ovr_full) else $error("overrun without full");
  a_ovr_hold: assert property (p_ovr_hold) else $error("overrun dropped");
  a_noise: assert property (p_noise) else $error("noise without avail");
endmodule // urxf_checker

bind urxf_receiver urxf_checker u_chk (
  .core_clk_i(core_clk_i),
  .nrst_i(nrst_i),
  .rx_enable_i(rx_enable_i),
  .rx_irq_enable_i(rx_irq_enable_i),
  .fifo_trig_sel_i(fifo_trig_sel_i),
  .data_rd_i(data_rd_i),
  .rx_pin_owned_o(rx_pin_owned_o),
  .rx_count_reg_o(rx_count_reg_o),
  .rx_avail_flag_o(rx_avail_flag_o),
  .rx_idle_flag_o(rx_idle_flag_o),
  .overrun_flag_o(overrun_flag_o),
  .noise_flag_o(noise_flag_o),
  .rx_irq_o(rx_irq_o)
);

// ### verification/urxf_line_model.sv
// Remote serial transmitter driving the receive line.
// Assumes tick_clks core clocks per oversample tick; changes at falling edges.
module urxf_line_model #(
  parameter int TICK = 2
) (
  input wire logic core_clk_i,
  output logic line_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Bench retunes this between frames when it changes the baud setting
  int tick_clks = TICK;
  initial line_o = 1'b1;

  task automatic hold(input logic lvl, input int n);
    line_o = lvl;
    repeat (n) @(negedge core_clk_i);
  endtask

  // -----------------------------------------------
  // Frame sender
  // -----------------------------------------------
  // start, data LSB first, stops
  task automatic send(input logic [8:0] w, input int nbits, input int nstop,
                      input logic [1:0] stops, input int glitch);
    hold(1'b0, 16 * tick_clks);
    for (int i = 0; i < nbits; i++) begin
      // One-tick spike on the middle vote sample; majority must outvote it
      if (i == glitch) begin
        hold(w[i], 7 * tick_clks);
        hold(!w[i], tick_clks);
        hold(w[i], 8 * tick_clks);
      end else begin
        hold(w[i], 16 * tick_clks);
      end
    end
    hold(stops[0], 16 * tick_clks);
    if (nstop == 2) begin
      hold(stops[1], 16 * tick_clks);
    end
    hold(1'b1, 16 * tick_clks);
  endtask
endmodule // urxf_line_model

// ### verification/urxf_receiver_tb.sv
// Self-checking bench for the serial receiver.
// Assumes fast mode, divisor 1 (32 clocks a bit), then slow mode, divisor 0 (64).
module urxf_receiver_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic rx_enable_i = 1'b0;
  logic word_len_sel_i = 1'b0;
  logic parity_enable_i = 1'b0;
  logic stop_count_sel_i = 1'b0;
  logic rx_irq_enable_i = 1'b0;
  logic status_rd_i = 1'b0;
  logic data_rd_i = 1'b0;
  logic [1:0] parity_type_sel_i = 2'h0;
  logic [1:0] fifo_trig_sel_i = 2'h3;
  logic line, owned, avail, idle, ovr, noise, ferr, perr, irq, good, pbit;
  logic [8:0] dout;
  logic [2:0] cnt;
  logic [6:0] d7 = 7'h35;
  logic [7:0] baud_lo = 8'h01;
  logic [2:0] baud_mode = 3'h1;
  int n_mismatch = 0;
  int comparisons = 0;

  always #2.5 core_clk_i = ~core_clk_i;

  urxf_line_model #(.TICK(2)) u_line (.core_clk_i(core_clk_i), .line_o(line));
  urxf_receiver u_dut (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .serial_in_pin_i(line),
    .rx_enable_i(rx_enable_i),
    .word_len_sel_i(word_len_sel_i),
    .parity_enable_i(parity_enable_i),
    .parity_type_sel_i(parity_type_sel_i),
    .stop_count_sel_i(stop_count_sel_i),
    .baud_div_high_i(8'h00),
    .baud_div_low_i(baud_lo),
    .baud_mode_sel_i(baud_mode),
    .rx_irq_enable_i(rx_irq_enable_i),
    .fifo_trig_sel_i(fifo_trig_sel_i),
    .status_rd_i(status_rd_i),
    .data_rd_i(data_rd_i),
    .rx_pin_owned_o(owned),
    .rx_data_fifo_reg_o(dout),
    .rx_count_reg_o(cnt),
    .rx_avail_flag_o(avail),
    .rx_idle_flag_o(idle),
    .overrun_flag_o(ovr),
    .noise_flag_o(noise),
    .framing_flag_o(ferr),
    .parity_flag_o(perr),
    .rx_irq_o(irq)
  );

  // -----------------------------------------------
  // Tasks
  // -----------------------------------------------
  task automatic check(input string what, input logic [8:0] exp, input logic [8:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Status access then data read: the full clear sequence every time
  task automatic read_word(input logic [8:0] exp);
    status_rd_i = 1'b1;
    @(negedge core_clk_i);
    status_rd_i = 1'b0;
    data_rd_i = 1'b1;
    @(negedge core_clk_i);
    data_rd_i = 1'b0;
    @(negedge core_clk_i);
    check("data", exp, dout);
  endtask

  task automatic give_verdict;
    $display("Comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // -----------------------------------------------
  // Watchdog, about three times the expected run
  // -----------------------------------------------
  initial begin
    repeat (24000) @(posedge core_clk_i);
    n_mismatch++;
    give_verdict();
  end

  // -----------------------------------------------
  // Tests
  // -----------------------------------------------
  initial begin
    repeat (3) @(negedge core_clk_i);
    nrst_i = 1'b1;
    check("count", 9'h0, 9'(cnt));
    check("idle", 9'h1, 9'(idle));
    rx_enable_i = 1'b1;
    rx_irq_enable_i = 1'b1;
    @(negedge core_clk_i);
    check("owned", 9'h1, 9'(owned));
    // The receiver needs a few ticks to reach the hunt before a start bit
    repeat (8) @(negedge core_clk_i);
    for (int i = 1; i < 6; i++) begin
      u_line.send(9'(i * 17), 8, 1, 2'b11, -1);
      if (i == 3) check("irq", 9'h0, 9'(irq));
    end
    check("count", 9'h4, 9'(cnt));
    check("overrun", 9'h1, 9'(ovr));
    check("irq", 9'h1, 9'(irq));
    rx_irq_enable_i = 1'b0;
    @(negedge core_clk_i);
    check("irq", 9'h0, 9'(irq));
    rx_irq_enable_i = 1'b1;
    for (int i = 1; i < 5; i++) begin
      read_word(9'(i * 17));
      check("overrun", 9'h0, 9'(ovr));
    end
    check("count", 9'h0, 9'(cnt));
    check("avail", 9'h0, 9'(avail));
    $display("Test overrun done");
    parity_enable_i = 1'b1;
    for (int t = 0; t < 4; t++) begin
      parity_type_sel_i = 2'(t);
      good = (t == 0) ? ^d7 : (t == 1) ? ~^d7 : (t == 2);
      for (int b = 0; b < 2; b++) begin
        pbit = good ^ b[0];
        u_line.send({1'b0, pbit, d7}, 8, 1, 2'b11, -1);
        check("parity", 9'(b[0]), 9'(perr));
        read_word({2'b00, d7});
      end
    end
    $display("Test parity done");
    parity_enable_i = 1'b0;
    word_len_sel_i = 1'b1;
    stop_count_sel_i = 1'b1;
    u_line.send(9'h1a5, 9, 2, 2'b11, -1);
    check("framing", 9'h0, 9'(ferr));
    read_word(9'h1a5);
    u_line.send(9'h0c3, 9, 2, 2'b01, -1);
    check("framing", 9'h1, 9'(ferr));
    read_word(9'h0c3);
    check("framing", 9'h0, 9'(ferr));
    $display("Test framing done");
    word_len_sel_i = 1'b0;
    stop_count_sel_i = 1'b0;
    // Low far past a frame so the break word lands while low, then high so the hunt resumes
    u_line.hold(1'b0, 32 * 14);
    u_line.hold(1'b1, 32 * 12);
    check("count", 9'h1, 9'(cnt));
    check("framing", 9'h1, 9'(ferr));
    check("avail", 9'h1, 9'(avail));
    check("idle", 9'h1, 9'(idle));
    check("irq", 9'h0, 9'(irq));
    read_word(9'h000);
    $display("Test break done");
    u_line.send(9'h05a, 8, 1, 2'b11, 3);
    check("noise", 9'h1, 9'(noise));
    read_word(9'h05a);
    check("noise", 9'h0, 9'(noise));
    $display("Test noise done");
    // Slow mode with divisor 0 stretches each tick to four clocks
    baud_mode = 3'h0;
    baud_lo = 8'h00;
    u_line.tick_clks = 4;
    u_line.send(9'h03c, 8, 1, 2'b11, -1);
    read_word(9'h03c);
    $display("Test slow baud done");
    rx_enable_i = 1'b0;
    @(negedge core_clk_i);
    check("owned", 9'h0, 9'(owned));
    give_verdict();
  end
endmodule // urxf_receiver_tb
